// ==== dio_pkg.sv ====
// constants shared by the filtered digital io block
package dio_pkg;
    localparam int NUM_LINES = 16;
    localparam int PORT_BITS = 8;
    localparam int FILT_W = 5;
    localparam int FILT_MAX = 20;
    localparam int CNT_W = 21;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_HZ = 8_000_000;
    localparam int TICK_GRAIN = 1_000_000;
    localparam int TICK_STEP = TICK_HZ / TICK_GRAIN;
    localparam int TICK_MOD = CLK_HZ / TICK_GRAIN;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_INPUT = 8'h00;
    localparam logic [7:0] OFF_OUTPUT = 8'h04;
    localparam logic [7:0] OFF_FILTER = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_EDGE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [15:0] RST_OUTPUT = 16'h0000;
    localparam logic [4:0] RST_FILTER = 5'h00;
    localparam logic [15:0] RST_MASK = 16'hffff;
    localparam logic [15:0] RST_EDGE = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dio_pkg

// ==== level_if.sv ====
// filtered input levels passed from the filter to the edge detector
`timescale 1ns/1ps
interface level_if #(parameter int WIDTH = 16);
    logic [WIDTH-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface : level_if

// ==== input_filter.sv ====
// input synchroniser, inversion and shared-setting debounce filter
`timescale 1ns/1ps
module input_filter #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] input_lines_n,
    input wire logic [dio_pkg::FILT_W-1:0] filt_setting,
    level_if.src lvl
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] filt;
    logic [3:0] acc;
    logic tick;
    wire logic [4:0] acc_sum = 5'(acc) + 5'(dio_pkg::TICK_STEP);
    wire logic acc_wrap = acc_sum >= 5'(dio_pkg::TICK_MOD);
    wire logic bypass = filt_setting == 5'h00;
    wire logic [dio_pkg::CNT_W-1:0] limit = dio_pkg::CNT_W'(1) << filt_setting;

    // 8 mhz sample enable from the 10 mhz clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc <= 4'h0;
            tick <= 1'b0;
        end else begin
            acc <= acc_wrap ? 4'(acc_sum - 5'(dio_pkg::TICK_MOD)) : acc_sum[3:0];
            tick <= acc_wrap;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= input_lines_n;
            sync2 <= sync1;
        end
    end

    assign raw = ~sync2;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic last;
            logic [dio_pkg::CNT_W-1:0] cnt;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    last <= 1'b0;
                    cnt <= '0;
                end else if (tick) begin
                    if (raw[i] != last) begin
                        last <= raw[i];
                        cnt <= '0;
                    end else if (cnt != limit) begin
                        cnt <= dio_pkg::CNT_W'(cnt + dio_pkg::CNT_W'(1));
                    end
                end
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    filt[i] <= 1'b0;
                end else if (bypass) begin
                    filt[i] <= raw[i];
                end else if (cnt == limit) begin
                    filt[i] <= last;
                end
            end
        end
    endgenerate

    assign lvl.level = filt;
endmodule : input_filter

// ==== edge_irq.sv ====
// per-input edge detection with mask, edge select and sticky status
`timescale 1ns/1ps
module edge_irq #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    level_if.dst lvl,
    input wire logic [WIDTH-1:0] irq_mask,
    input wire logic [WIDTH-1:0] edge_sel,
    input wire logic status_clear,
    output logic [WIDTH-1:0] status
);
    logic [WIDTH-1:0] prev;
    wire logic [WIDTH-1:0] rise = lvl.level & ~prev;
    wire logic [WIDTH-1:0] fall = prev & ~lvl.level;
    wire logic [WIDTH-1:0] hit = (edge_sel & fall) | (~edge_sel & rise);
    wire logic [WIDTH-1:0] event_bits = hit & ~irq_mask;
    wire logic [WIDTH-1:0] kept = status_clear ? '0 : status;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev <= '0;
            status <= dio_pkg::RST_STATUS;
        end else begin
            prev <= lvl.level;
            status <= kept | event_bits;
        end
    end
endmodule : edge_irq

// ==== dio_top.sv ====
// filtered digital io port with edge interrupts behind an axi4-lite slave
// Behaviour
// - sixteen inputs as two byte ports
// - sixteen outputs as two byte ports
// - low pin level reads as one
// - written one turns output transistor on
// - reset clears all output bits
// - output readback returns latch, no side effect
// - pass level only after stable filter time
// - filter time is two-power-n 8 MHz ticks
// - setting zero bypasses filter, resets zero
// - one filter setting for all inputs
// - inputs raise interrupts from filtered level changes
// - masked inputs raise no request
// - all inputs masked after reset
// - edge select chooses rising or falling read value
// - edge select bits reset to zero
// - status read clears status and request
// - status bits reset to zero
// - masked input never sets status
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dio_top #(
    parameter int WIDTH = dio_pkg::NUM_LINES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] input_lines_n,
    output logic [WIDTH-1:0] output_lines_oe,
    output logic irq,
    input wire logic [dio_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [dio_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    logic [WIDTH-1:0] out_latch;
    logic [dio_pkg::FILT_W-1:0] filt_setting;
    logic [WIDTH-1:0] irq_mask;
    logic [WIDTH-1:0] edge_sel;
    logic [WIDTH-1:0] status;
    logic [dio_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_held;
    logic w_held;

    level_if #(.WIDTH(WIDTH)) lvl ();

    input_filter #(.WIDTH(WIDTH)) u_filter (
        .ref_clk(ref_clk),
        .rst(rst),
        .input_lines_n(input_lines_n),
        .filt_setting(filt_setting),
        .lvl(lvl.src)
    );

    // merge a write into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // write channel
    wire logic aw_hs = awvalid & awready;
    wire logic w_hs = wvalid & wready;
    wire logic wr_fire = aw_held & w_held & ~bvalid;
    wire logic next_aw_held = (aw_held | aw_hs) & ~wr_fire;
    wire logic next_w_held = (w_held | w_hs) & ~wr_fire;
    wire logic next_bvalid = wr_fire | (bvalid & ~bready);
    wire logic wr_out = wr_fire && aw_addr_q == dio_pkg::OFF_OUTPUT;
    wire logic wr_filt = wr_fire && aw_addr_q == dio_pkg::OFF_FILTER;
    wire logic wr_mask = wr_fire && aw_addr_q == dio_pkg::OFF_MASK;
    wire logic wr_edge = wr_fire && aw_addr_q == dio_pkg::OFF_EDGE;
    wire logic wr_ro = aw_addr_q == dio_pkg::OFF_INPUT || aw_addr_q == dio_pkg::OFF_STATUS;
    wire logic wr_hit = wr_out | wr_filt | wr_mask | wr_edge | wr_ro;
    wire logic [31:0] out_merged = merge(32'(out_latch), w_data_q, w_strb_q);
    wire logic [31:0] filt_merged = merge(32'(filt_setting), w_data_q, w_strb_q);
    wire logic [31:0] mask_merged = merge(32'(irq_mask), w_data_q, w_strb_q);
    wire logic [31:0] edge_merged = merge(32'(edge_sel), w_data_q, w_strb_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awready <= ~next_aw_held & ~next_bvalid;
            wready <= ~next_w_held & ~next_bvalid;
            if (aw_hs) begin
                aw_addr_q <= awaddr;
            end
            if (w_hs) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= dio_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_hit || wr_ro) ? dio_pkg::RESP_OKAY : dio_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_latch <= dio_pkg::RST_OUTPUT;
            filt_setting <= dio_pkg::RST_FILTER;
            irq_mask <= dio_pkg::RST_MASK;
            edge_sel <= dio_pkg::RST_EDGE;
        end else begin
            if (wr_out) begin
                out_latch <= out_merged[WIDTH-1:0];
            end
            if (wr_filt) begin
                filt_setting <= filt_merged[dio_pkg::FILT_W-1:0];
            end
            if (wr_mask) begin
                irq_mask <= mask_merged[WIDTH-1:0];
            end
            if (wr_edge) begin
                edge_sel <= edge_merged[WIDTH-1:0];
            end
        end
    end

    // a set transistor pulls its open-collector pin low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_lines_oe <= '0;
        end else begin
            output_lines_oe <= out_latch;
        end
    end

    // read channel
    wire logic ar_hs = arvalid & arready;
    wire logic next_rbusy = (rvalid & ~rready) | ar_hs;
    wire logic rd_status = ar_hs && araddr == dio_pkg::OFF_STATUS;
    wire logic rd_in = araddr == dio_pkg::OFF_INPUT;
    wire logic rd_out = araddr == dio_pkg::OFF_OUTPUT;
    wire logic rd_filt = araddr == dio_pkg::OFF_FILTER;
    wire logic rd_mask = araddr == dio_pkg::OFF_MASK;
    wire logic rd_edge = araddr == dio_pkg::OFF_EDGE;
    wire logic rd_stat = araddr == dio_pkg::OFF_STATUS;
    wire logic rd_hit = rd_in | rd_out | rd_filt | rd_mask | rd_edge | rd_stat;
    wire logic [31:0] rd_mux =
        rd_in ? 32'(lvl.level) :
        rd_out ? 32'(out_latch) :
        rd_filt ? 32'(filt_setting) :
        rd_mask ? 32'(irq_mask) :
        rd_edge ? 32'(edge_sel) :
        rd_stat ? 32'(status) : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= dio_pkg::RESP_OKAY;
        end else begin
            arready <= ~next_rbusy;
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_hit ? dio_pkg::RESP_OKAY : dio_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    edge_irq #(.WIDTH(WIDTH)) u_edge (
        .ref_clk(ref_clk),
        .rst(rst),
        .lvl(lvl.dst),
        .irq_mask(irq_mask),
        .edge_sel(edge_sel),
        .status_clear(rd_status),
        .status(status)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |status;
        end
    end
endmodule : dio_top

// ==== dio_chk.sv ====
// assertion checker for the filtered digital io block
`timescale 1ns/1ps
module dio_chk #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] output_lines_oe,
    input wire logic irq,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire stat_rd = arvalid && arready && araddr == 8'h14;
    wire ar_take = arvalid && arready;

    a_out_reset: assert property (disable iff (1'b0) rst [*2] |=> output_lines_oe == '0)
        else $error("outputs on after reset");
    a_irq_reset: assert property (disable iff (1'b0) rst [*2] |=> !irq)
        else $error("request high after reset");
    a_irq_drop: assert property ($fell(irq) |-> $past(stat_rd, 2))
        else $error("request fell without status read");
    a_b_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    a_r_answer: assert property (ar_take |=> rvalid)
        else $error("read answer late");
    a_unmapped: assert property (ar_take && araddr > 8'h14 |=> rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_ar_block: assert property (rvalid |-> !arready)
        else $error("read taken while one outstanding");
    a_aw_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while one outstanding");

    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (ar_take && araddr > 8'h14);
    c_write: cover property (bvalid && bready);
endmodule : dio_chk

bind dio_top dio_chk #(.WIDTH(WIDTH)) i_dio_chk (.ref_clk(ref_clk), .rst(rst), .output_lines_oe(output_lines_oe),
    .irq(irq), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

// ==== field_side.sv ====
// field side model: switches with pull-ups and pulled-up loads
`timescale 1ns/1ps
module field_side (
    input wire logic [15:0] closed,
    input wire logic [15:0] drive_on,
    output logic [15:0] pins_n,
    output logic [15:0] load_n
);
    assign pins_n = ~closed;
    assign load_n = ~drive_on;
endmodule : field_side

// ==== dio_top_tb.sv ====
// self-checking bench for the filtered digital io block
`timescale 1ns/1ps
module dio_top_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h51;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, wresp;
    logic [15:0] closed = 16'h0, pins_n, oe, load_n;
    int errors = 0, n_compared = 0, cyc = 0;
    int m [6];
    always #50 ref_clk = ~ref_clk;
    field_side i_field_side (.closed(closed), .drive_on(oe), .pins_n(pins_n), .load_n(load_n));
    dio_top i_dio_top (.ref_clk(ref_clk), .rst(rst), .input_lines_n(pins_n), .output_lines_oe(oe), .irq(irq),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        wresp = bresp;
        for (int i = 0; i < 2; i++) begin
            if (s[i] && a inside {8'h04, 8'h08, 8'h0c, 8'h10}) m[a[4:2]][8*i +: 8] = d[8*i +: 8];
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk($sformatf("reg %h", a), d, exp);
        chk("read resp", {30'h0, r}, 32'h0);
    endtask : rc
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        logic [31:0] d, v;
        logic [1:0] r;
        m = '{0, 0, 0, 32'hffff, 0, 0};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 1; i < 6; i++) rc(8'(4 * i), m[i]);
        rd(8'h40, d, r);
        chk("unmapped resp", {30'h0, r}, 32'h2);
        wr(8'h40, 32'hffff, 4'hf);
        chk("unmapped write resp", {30'h0, wresp}, 32'h2);
        rc(8'h04, m[1]);
        $display("test reset and map done");
        for (int i = 0; i < 6; i++) begin
            v = xs();
            wr(8'h04, v, 4'(xs()));
            chk("write resp", {30'h0, wresp}, 32'h0);
            rc(8'h04, m[1]);
            @(posedge ref_clk);
            chk("load pins", {16'h0, load_n}, ~m[1] & 32'hffff);
        end
        $display("test outputs done");
        closed <= 16'(xs());
        repeat (4) @(posedge ref_clk);
        rc(8'h00, {16'h0, closed});
        wr(8'h08, 32'h3, 4'hf);
        v = {16'h0, closed};
        closed <= ~closed;
        repeat (3) @(posedge ref_clk);
        rc(8'h00, v);
        repeat (20) @(posedge ref_clk);
        rc(8'h00, ~v & 32'hffff);
        v = {16'h0, closed};
        closed <= closed ^ 16'h00ff;
        repeat (4) @(posedge ref_clk);
        rc(8'h00, v);
        closed <= closed ^ 16'h00ff;
        repeat (20) @(posedge ref_clk);
        rc(8'h00, v);
        $display("test filter done");
        wr(8'h08, 32'h0, 4'hf);
        closed <= 16'h0004;
        repeat (4) @(posedge ref_clk);
        wr(8'h10, 32'h4, 4'hf);
        wr(8'h0c, 32'hfffa, 4'hf);
        rc(8'h14, 32'h0);
        closed <= 16'h0003;
        repeat (6) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rc(8'h14, 32'h5);
        repeat (3) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        rc(8'h14, 32'h0);
        $display("test irq done");
        summarize();
    end
endmodule : dio_top_tb
